// *** tmrflg_pkg.sv ***
// package for the timer 1 event flag register block
// Notes on behaviour
// RL1: capture pin event sets flag bit 5
// RL2: capture-as-top mode: top reach sets capture flag
// RL3: capture vector execution clears capture flag
// RL4: writing one to bit 5 clears it
// RL5: compare B flag bit 2, tick after match
// RL6: forced compare B strobe never sets flag
// RL7: compare B cleared by vector or written one
// RL8: compare A flag bit 1, tick after match
// RL9: forced compare A strobe never sets flag
// RL10: compare A cleared by vector or written one
// RL11: overflow flag bit 0, set per waveform mode
// RL12: overflow cleared by vector or written one
// RL13: data 0x36, io 0x16, resets to zero
// RL14: io address is data address minus 0x20
// RL15: extended range from 0x60 data access only
// RL16: unused bits read zero, zero writes ignored
// RL17: request when flag, enable and global enable
package tmrflg_pkg;
	localparam int unsigned ADDR_W       = 16;
	localparam logic [15:0] FLAGS_DATA_ADDR = 16'h0036;
	localparam logic [15:0] IO_TO_DATA_OFS  = 16'h0020;
	localparam logic [15:0] EXT_IO_BASE     = 16'h0060;
	localparam logic [15:0] IO_SPACE_TOP    = 16'h003f;
	localparam logic [7:0]  FLAGS_RESET     = 8'h00;
	localparam int unsigned CAPTURE_BIT   = 5;
	localparam int unsigned COMPARE_B_BIT = 2;
	localparam int unsigned COMPARE_A_BIT = 1;
	localparam int unsigned WRAP_BIT      = 0;
	localparam logic [3:0]  WGM_NORMAL    = 4'h0;
	localparam logic [3:0]  WGM_CTC_OCRA  = 4'h4;
	localparam logic [3:0]  WGM_CTC_ICR   = 4'hc;
	localparam logic [3:0]  WGM_PFC_ICR   = 4'h8;
	localparam logic [3:0]  WGM_PC_ICR    = 4'ha;
	localparam logic [3:0]  WGM_FAST_ICR  = 4'he;
	localparam logic [3:0]  WGM_PC_8BIT   = 4'h1;
	localparam logic [3:0]  WGM_PC_9BIT   = 4'h2;
	localparam logic [3:0]  WGM_PC_10BIT  = 4'h3;
	localparam logic [3:0]  WGM_PFC_OCRA  = 4'h9;
	localparam logic [3:0]  WGM_PC_OCRA   = 4'hb;

	// counter side events, acted on only with timer clock enable; capture pin synchronised every clock
	typedef struct packed {
		logic        tick;
		logic        capture_input_pin;
		logic        at_top;
		logic        at_bottom;
		logic        at_max;
		logic        match_a;
		logic        match_b;
		logic        force_compare_a_strobe;
		logic        force_compare_b_strobe;
		logic [3:0]  waveform_mode_select;
	} tmrflg_evt_s;

	// cpu register access, io or data space
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic              io_space;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} tmrflg_bus_s;

	typedef struct packed {
		logic capture_ack;
		logic compare_a_ack;
		logic compare_b_ack;
		logic wrap_ack;
	} tmrflg_ack_s;

	typedef struct packed {
		logic capture_event_flag;
		logic compare_b_flag;
		logic compare_a_flag;
		logic counter_wrap_flag;
		logic pin_sync1;
		logic pin_sync2;
		logic pin_prev;
		logic match_a_pend;
		logic match_b_pend;
		logic [7:0] rdata;
	} tmrflg_state_s;
endpackage : tmrflg_pkg

// *** tmrflg_flags.sv ***
// timer 1 event flag register with vector acknowledges and requests
`timescale 1ns/10ps
`default_nettype none
module tmrflg_flags (
	input  wire logic                mclk,
	input  wire logic                reset_n,
	input  wire tmrflg_pkg::tmrflg_evt_s evt,
	input  wire tmrflg_pkg::tmrflg_bus_s bus,
	input  wire tmrflg_pkg::tmrflg_ack_s ack,
	input  wire logic [3:0]          irq_enable,
	input  wire logic                global_irq_enable,
	output logic [7:0]               rdata,
	output logic                     sel,
	output logic [3:0]               irq_request
);
	import tmrflg_pkg::*;

	tmrflg_state_s s_q;
	tmrflg_state_s s_d;
	logic [15:0]   data_addr;
	logic          hit;
	logic          wr_hit;
	logic          cap_set;
	logic          wrap_set;
	logic          icr_top;
	logic [7:0]    flags_view;

	always_comb begin
		// io instructions see the low window only, rebased by 0x20
		data_addr = bus.addr + IO_TO_DATA_OFS; // see RL14
		if (!bus.io_space) begin
			data_addr = bus.addr;
		end
		// extended range is never reachable by io instructions
		hit = (data_addr == FLAGS_DATA_ADDR)
			&& (!bus.io_space || bus.addr <= IO_SPACE_TOP)
			&& (data_addr < EXT_IO_BASE || !bus.io_space); // see RL13 RL15
		wr_hit = hit && bus.wr;
		icr_top = (evt.waveform_mode_select == WGM_CTC_ICR)
			|| (evt.waveform_mode_select == WGM_PFC_ICR)
			|| (evt.waveform_mode_select == WGM_PC_ICR)
			|| (evt.waveform_mode_select == WGM_FAST_ICR);
		// pin edge only counts when capture register is not top
		cap_set = evt.tick && (icr_top ? evt.at_top
			: (s_q.pin_sync2 && !s_q.pin_prev)); // see RL1 RL2
		unique case (evt.waveform_mode_select)
			WGM_NORMAL, WGM_CTC_OCRA, WGM_CTC_ICR:
				wrap_set = evt.tick && evt.at_max; // see RL11
			WGM_PFC_ICR, WGM_PFC_OCRA, WGM_PC_ICR, WGM_PC_OCRA,
			WGM_PC_8BIT, WGM_PC_9BIT, WGM_PC_10BIT:
				wrap_set = evt.tick && evt.at_bottom;
			default:
				wrap_set = evt.tick && evt.at_top;
		endcase
		flags_view = 8'h00; // see RL16
		flags_view[CAPTURE_BIT]   = s_q.capture_event_flag;
		flags_view[COMPARE_B_BIT] = s_q.compare_b_flag;
		flags_view[COMPARE_A_BIT] = s_q.compare_a_flag;
		flags_view[WRAP_BIT]      = s_q.counter_wrap_flag;

		s_d = s_q;
		s_d.pin_sync1 = evt.capture_input_pin;
		s_d.pin_sync2 = s_q.pin_sync1;
		if (evt.tick) begin
			s_d.pin_prev = s_q.pin_sync2;
			// match seen now, flagged on the next timer tick
			s_d.match_a_pend = evt.match_a
				&& !evt.force_compare_a_strobe; // see RL8 RL9
			s_d.match_b_pend = evt.match_b
				&& !evt.force_compare_b_strobe; // see RL5 RL6
		end
		// clears first so a same-cycle set wins
		if (ack.capture_ack || (wr_hit && bus.wdata[CAPTURE_BIT])) begin
			s_d.capture_event_flag = 1'b0; // see RL3 RL4
		end
		if (ack.compare_b_ack || (wr_hit && bus.wdata[COMPARE_B_BIT])) begin
			s_d.compare_b_flag = 1'b0; // see RL7
		end
		if (ack.compare_a_ack || (wr_hit && bus.wdata[COMPARE_A_BIT])) begin
			s_d.compare_a_flag = 1'b0; // see RL10
		end
		if (ack.wrap_ack || (wr_hit && bus.wdata[WRAP_BIT])) begin
			s_d.counter_wrap_flag = 1'b0; // see RL12
		end
		if (cap_set) begin
			s_d.capture_event_flag = 1'b1;
		end
		if (evt.tick && s_q.match_b_pend) begin
			s_d.compare_b_flag = 1'b1; // see RL5
		end
		if (evt.tick && s_q.match_a_pend) begin
			s_d.compare_a_flag = 1'b1; // see RL8
		end
		if (wrap_set) begin
			s_d.counter_wrap_flag = 1'b1;
		end
		s_d.rdata = (hit && bus.rd) ? flags_view : 8'h00;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_q <= '0; // see RL13
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign sel   = hit;
	// index 3 capture, 2 compare b, 1 compare a, 0 wrap
	assign irq_request = {s_q.capture_event_flag, s_q.compare_b_flag,
		s_q.compare_a_flag, s_q.counter_wrap_flag}
		& irq_enable & {4{global_irq_enable}}; // see RL17
endmodule : tmrflg_flags
`default_nettype wire

// *** tmrflg_flags_sva.sv ***
// checker on the event flag register ports
`timescale 1ns/10ps
`default_nettype none
module tmrflg_flags_sva (
	input wire logic                    mclk,
	input wire logic                    reset_n,
	input wire tmrflg_pkg::tmrflg_evt_s evt,
	input wire tmrflg_pkg::tmrflg_bus_s bus,
	input wire tmrflg_pkg::tmrflg_ack_s ack,
	input wire logic [7:0]              rdata,
	input wire logic                    sel,
	input wire logic [3:0]              irq_enable,
	input wire logic                    global_irq_enable,
	input wire logic [3:0]              irq_request);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_data_hit: assert property (bus.rd && !bus.io_space &&
		bus.addr == 16'h0036 |-> sel) else $error("no data hit");
	a_io_hit: assert property (bus.rd && bus.io_space &&
		bus.addr == 16'h0016 |-> sel) else $error("no io hit");
	a_io_ext_miss: assert property (bus.io_space &&
		bus.addr > 16'h003f |-> !sel) else $error("io hit above window");
	a_miss_zero: assert property (bus.rd && !sel |=> !rdata)
		else $error("miss read not zero");
	a_unused_zero: assert property (!rdata[7:6] && !rdata[4:3])
		else $error("unused bit set");
	a_ack_clear_a: assert property (ack.compare_a_ack && !evt.tick
		|=> !irq_request[1]) else $error("ack a kept");
	a_ack_capture: assert property (ack.capture_ack && !evt.tick
		|=> !irq_request[3]) else $error("ack capture kept");
	a_w1c_clear: assert property (bus.wr && sel && bus.wdata[0] &&
		!evt.tick |=> !irq_request[0]) else $error("wrap kept");
	a_irq_global: assert property (!global_irq_enable |-> !irq_request)
		else $error("request without global enable");
	a_irq_masked: assert property (!(irq_request & ~irq_enable))
		else $error("request on masked channel");
endmodule : tmrflg_flags_sva
bind tmrflg_flags tmrflg_flags_sva u_sva (.*);
`default_nettype wire

// *** tmrflg_cpu_model.sv ***
// cpu side model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module tmrflg_cpu_model (
	input  wire logic                    mclk,
	output var  tmrflg_pkg::tmrflg_bus_s bus);
	initial bus = '0;
	// held a whole cycle so exactly one rising edge takes it
	task automatic acc(logic w, logic io, logic [15:0] a, logic [7:0] d);
		@(negedge mclk);
		bus <= {~w, w, io, a, d};
		@(negedge mclk);
		bus <= '0;
	endtask : acc
endmodule : tmrflg_cpu_model
`default_nettype wire

// *** tb_timer1_interrupt_flags.sv ***
// bench for the timer 1 event flag register
`timescale 1ns/10ps
`default_nettype none
module tb_timer1_interrupt_flags;
	logic                    mclk = 0, reset_n = 0;
	logic [7:0]              rdata;
	logic [3:0]              irq_request;
	logic [3:0]              irq_en = 4'hf;
	logic                    gie = 1'b1;
	tmrflg_pkg::tmrflg_evt_s evt = '0;
	tmrflg_pkg::tmrflg_ack_s ack = '0;
	tmrflg_pkg::tmrflg_bus_s bus;
	int                      error_cnt = 0, compares = 0, cyc = 0;
	logic [32:0]             rows [5] = '{33'h10f000000, 33'h19c00d827,
		33'h140c00020, 33'h110400001, 33'h19c0c0106};
	tmrflg_cpu_model cpu (.mclk(mclk), .bus(bus));
	tmrflg_flags DUT (.mclk(mclk), .reset_n(reset_n), .evt(evt), .bus(bus),
		.ack(ack), .irq_enable(irq_en), .global_irq_enable(gie),
		.rdata(rdata), .sel(), .irq_request(irq_request));
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) if (++cyc == 500) begin
		error_cnt++;
		print_verdict();
	end
	task automatic chk_irq(logic [3:0] e);
		compares++;
		if (irq_request !== e) begin
			error_cnt++;
			$display("[FAIL] %0t irq %h", $time, irq_request);
		end
	endtask : chk_irq
	task automatic rd(logic io, logic [15:0] a, logic [7:0] e);
		cpu.acc(1'b0, io, a, 8'h00);
		compares++;
		error_cnt += int'(rdata !== e);
		if (rdata !== e) $display("[FAIL] %0t read %h", $time, rdata);
	endtask : rd
	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0 && cyc < 500)
			$display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (6) @(negedge mclk);
		reset_n <= 1;
		foreach (rows[i]) begin
			evt <= rows[i][32:20];
			repeat (6) @(negedge mclk);
			evt <= 13'h1000;
			ack <= rows[i][19:16];
			@(negedge mclk);
			evt <= '0;
			ack <= '0;
			cpu.acc(1'b1, 1'b0, 16'h0036, rows[i][15:8]);
			rd(1'b0, 16'h0036, rows[i][7:0]);
			rd(1'b1, 16'h0056, 8'h00);
			cpu.acc(1'b1, 1'b1, 16'h0016, 8'hff);
		end
		// all four flags, then the enables gating the requests
		evt <= 13'h19c0;
		repeat (3) @(negedge mclk);
		evt <= '0;
		@(negedge mclk);
		chk_irq(4'hf);
		irq_en <= 4'h5;
		@(negedge mclk);
		chk_irq(4'h5);
		gie <= 1'b0;
		@(negedge mclk);
		chk_irq(4'h0);
		gie <= 1'b1;
		irq_en <= 4'hf;
		// vector acknowledge with no tick pending
		ack <= 4'hc;
		@(negedge mclk);
		ack <= '0;
		@(negedge mclk);
		chk_irq(4'h5);
		// reset in mid-run wipes the remaining flags
		reset_n <= 1'b0;
		@(negedge mclk);
		chk_irq(4'h0);
		reset_n <= 1'b1;
		rd(1'b1, 16'h0016, 8'h00);
		print_verdict();
	end
endmodule : tb_timer1_interrupt_flags
`default_nettype wire
